// *** display_status_sleep_regs.svh ***
// Command codes, status field positions, reset values and timing counts
`ifndef DISPLAY_STATUS_SLEEP_REGS_SVH
`define DISPLAY_STATUS_SLEEP_REGS_SVH

`define CMD_READ_IMAGE_SHORT   16'h000D
`define CMD_READ_IMAGE_WIDE    16'h0D00
`define CMD_READ_SIGNAL_SHORT  16'h000E
`define CMD_READ_SIGNAL_WIDE   16'h0E00
`define CMD_READ_DIAG_SHORT    16'h000F
`define CMD_READ_DIAG_WIDE     16'h0F00
`define CMD_SLEEP_ENTER_SHORT  16'h0010
`define CMD_SLEEP_ENTER_WIDE   16'h1000
`define CMD_SLEEP_EXIT_SHORT   16'h0011
`define CMD_SLEEP_EXIT_WIDE    16'h1100

`define IMAGE_INVERSION_BIT    5
`define IMAGE_ALL_WHITE_BIT    4
`define IMAGE_ALL_BLACK_BIT    3
`define IMAGE_MODE_RESET       8'h00
`define IMAGE_MODE_MASK        8'h38

`define SIGNAL_MODE_MASK       8'hC1
`define SIGNAL_MODE_RESET      8'h00

`define DIAG_REG_LOAD_BIT      7
`define DIAG_FUNCTION_BIT      6
`define DIAG_ATTACH_BIT        5
`define DIAG_GLASS_BIT         4
`define DIAG_CHECKSUM_BIT      0
`define DIAG_RESET             8'h00
`define DIAG_ZERO_MASK         8'h0E

`define CLK_PERIOD_NS          50
`define STEP_TIME_NS           1000
`define STEP_CYCLES            ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_FRAMES           2

`endif

// *** display_status_sleep_pkg.sv ***
// Types shared by the status and sleep command logic
package display_status_sleep_pkg;

   typedef enum logic [2:0] {
      cmd_none,
      cmd_read_image,
      cmd_read_signal,
      cmd_read_diag,
      cmd_sleep_enter,
      cmd_sleep_exit
   } cmd_kind_t;

   typedef enum logic [3:0] {
      st_sleep,
      st_wake_osc,
      st_wake_dcdc,
      st_wake_charge,
      st_wake_blank,
      st_awake,
      st_slp_blank,
      st_slp_drain,
      st_slp_dcdc
   } power_state_t;

   typedef struct packed {
      logic osc_en;
      logic dcdc_en;
      logic scan_en;
      logic drain;
      logic offset_charge;
      logic blank;
   } power_ctrl_t;

   typedef struct packed {
      logic inversion_active_flag;
      logic all_white_flag;
      logic all_black_flag;
   } display_flags_t;

   typedef struct packed {
      logic reg_load_ok;
      logic function_ok;
      logic attach_ok;
      logic glass_ok;
      logic checksum_mismatch_flag;
   } diag_checks_t;

endpackage : display_status_sleep_pkg

// *** cmd_decode.sv ***
// Command code decoder for the status and sleep commands
`timescale 1ns/1ps
`include "display_status_sleep_regs.svh"

module cmd_decode
   import display_status_sleep_pkg::*;
(
   input  wire logic [15:0] cmd_code,
   output cmd_kind_t        cmd_kind
);

   always_comb begin
      unique case (cmd_code)
         `CMD_READ_IMAGE_SHORT, `CMD_READ_IMAGE_WIDE: begin
            cmd_kind = cmd_read_image;
         end
         `CMD_READ_SIGNAL_SHORT, `CMD_READ_SIGNAL_WIDE: begin
            cmd_kind = cmd_read_signal;
         end
         `CMD_READ_DIAG_SHORT, `CMD_READ_DIAG_WIDE: begin
            cmd_kind = cmd_read_diag;
         end
         `CMD_SLEEP_ENTER_SHORT, `CMD_SLEEP_ENTER_WIDE: begin
            cmd_kind = cmd_sleep_enter;
         end
         `CMD_SLEEP_EXIT_SHORT, `CMD_SLEEP_EXIT_WIDE: begin
            cmd_kind = cmd_sleep_exit;
         end
         default: begin
            cmd_kind = cmd_none;
         end
      endcase
   end

endmodule : cmd_decode

// *** step_timer.sv ***
// Down counter that times one step of the power sequence
`timescale 1ns/1ps

module step_timer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] load,
   output logic                  done
);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic             next_done;

   if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
      $error("step_timer WIDTH out of range");
   end

   always_comb begin
      next_count = count;
      if (start) begin
         next_count = load;
      end else if (count != '0) begin
         next_count = count - WIDTH'(1);
      end
      next_done = (count == WIDTH'(1)) && !start;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count <= '0;
         done  <= 1'b0;
      end else begin
         count <= next_count;
         done  <= next_done;
      end
   end

endmodule : step_timer

// *** display_status_sleep_cmds.sv ***
// Status read and sleep enter and exit command handling
//
// Notes on behaviour
// - Image-mode read returns byte, zero-reset, unused zero
// - Bit 5 shows colour inversion active
// - Bit 4 shows forced all-white display
// - Bit 3 shows forced all-black display
// - Signal-mode read: only bits 7,6,0 nonzero
// - Diagnostic read returns checks from last wake
// - Bits 7,6: register-load and function checks passed
// - Bits 5,4: attachment, glass; bits 3-1 zero
// - Bit 0 set on checksum mismatch
// - Sleep-in stops converter, oscillator, scanning
// - Command port works, registers kept while asleep
// - Sleep-in ignored when already asleep
// - Wake command leaves the sleep state
// - Sleep-in first blanks screen, display setting kept
// - Then drain panel, stop converter, stop oscillator
// - Status reads refused in partial display mode
// - Wake restarts supplies, charges, blanks two frames
`timescale 1ns/1ps
`include "display_status_sleep_regs.svh"

module display_status_sleep_cmds
   import display_status_sleep_pkg::*;
#(
   parameter int STEP_CYCLES  = `STEP_CYCLES,
   parameter int BLANK_FRAMES = `BLANK_FRAMES
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        soft_reset_req,
   input  wire logic        cmd_valid,
   input  wire logic [15:0] cmd_code,
   input  wire logic        partial_mode,
   input  display_flags_t   display_flags,
   input  wire logic [7:0]  signal_mode_bits,
   input  diag_checks_t     diag_checks,
   input  wire logic        frame_tick,
   output logic             rsp_valid,
   output logic             rsp_refused,
   output logic [7:0]       rsp_data,
   output power_ctrl_t      power_ctrl,
   output logic             asleep
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Parameter checks

   if (STEP_CYCLES < 1 || STEP_CYCLES > 255) begin : g_step_check
      $error("STEP_CYCLES out of range");
   end
   if (BLANK_FRAMES < 1 || BLANK_FRAMES > 15) begin : g_blank_check
      $error("BLANK_FRAMES out of range");
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam logic [7:0] STEP_LOAD  = 8'(STEP_CYCLES);
   localparam logic [3:0] BLANK_LAST = 4'(BLANK_FRAMES - 1);

   cmd_kind_t    cmd_kind;
   power_state_t state;
   power_state_t next_state;
   power_ctrl_t  next_power;
   logic         rst_all;
   logic         step_start;
   logic         next_step_start;
   logic         step_done;
   logic [3:0]   frame_count;
   logic [3:0]   next_frame_count;
   logic [7:0]   image_mode_status;
   logic [7:0]   next_image;
   logic [7:0]   signal_mode_status;
   logic [7:0]   next_signal;
   logic [7:0]   self_diagnostic_result;
   logic [7:0]   next_diag;
   logic         next_rsp_valid;
   logic         next_rsp_refused;
   logic [7:0]   next_rsp_data;
   logic         read_image_mode_cmd;
   logic         read_signal_mode_cmd;
   logic         read_self_diag_cmd;
   logic         sleep_enter_cmd;
   logic         sleep_exit_cmd;
   logic         read_cmd;

   function automatic power_ctrl_t power_for(input power_state_t s);
      power_ctrl_t p;
      p = '0;
      unique case (s)
         st_sleep: begin
            p = '0;
         end
         st_wake_osc: begin
            p.osc_en = 1'b1;
         end
         st_wake_dcdc: begin
            p.osc_en  = 1'b1;
            p.dcdc_en = 1'b1;
         end
         st_wake_charge: begin
            p.osc_en        = 1'b1;
            p.dcdc_en       = 1'b1;
            p.offset_charge = 1'b1;
         end
         st_wake_blank, st_slp_blank: begin
            p.osc_en  = 1'b1;
            p.dcdc_en = 1'b1;
            p.scan_en = 1'b1;
            p.blank   = 1'b1;
         end
         st_awake: begin
            p.osc_en  = 1'b1;
            p.dcdc_en = 1'b1;
            p.scan_en = 1'b1;
         end
         st_slp_drain: begin
            p.osc_en  = 1'b1;
            p.dcdc_en = 1'b1;
            p.drain   = 1'b1;
            p.blank   = 1'b1;
         end
         st_slp_dcdc: begin
            p.osc_en = 1'b1;
            p.blank  = 1'b1;
         end
         default: begin
            p = '0;
         end
      endcase
      return p;
   endfunction : power_for

   ////////////////////////////////////////////////////////////////////////////////////////
   // Command decode and step timer

   cmd_decode u_cmd_decode (
      .cmd_code (cmd_code),
      .cmd_kind (cmd_kind)
   );

   step_timer #(
      .WIDTH (8)
   ) u_step_timer (
      .clk_sys (clk_sys),
      .reset   (rst_all),
      .start   (step_start),
      .load    (STEP_LOAD),
      .done    (step_done)
   );

   assign rst_all              = reset || soft_reset_req;
   assign read_image_mode_cmd  = cmd_valid && (cmd_kind == cmd_read_image);
   assign read_signal_mode_cmd = cmd_valid && (cmd_kind == cmd_read_signal);
   assign read_self_diag_cmd   = cmd_valid && (cmd_kind == cmd_read_diag);
   assign sleep_enter_cmd      = cmd_valid && (cmd_kind == cmd_sleep_enter);
   assign sleep_exit_cmd       = cmd_valid && (cmd_kind == cmd_sleep_exit);
   assign read_cmd = read_image_mode_cmd || read_signal_mode_cmd || read_self_diag_cmd;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Power sequence

   always_comb begin
      next_state = state;
      unique case (state)
         st_sleep:       if (sleep_exit_cmd) next_state = st_wake_osc;
         st_wake_osc:    if (step_done) next_state = st_wake_dcdc;
         st_wake_dcdc:   if (step_done) next_state = st_wake_charge;
         st_wake_charge: if (step_done) next_state = st_wake_blank;
         st_wake_blank: begin
            if (frame_tick && frame_count == BLANK_LAST) next_state = st_awake;
         end
         st_awake:       if (sleep_enter_cmd) next_state = st_slp_blank;
         st_slp_blank:   if (step_done) next_state = st_slp_drain;
         st_slp_drain:   if (step_done) next_state = st_slp_dcdc;
         st_slp_dcdc:    if (step_done) next_state = st_sleep;
         default:        next_state = st_sleep;
      endcase
      next_step_start = (next_state != state) &&
                        (next_state inside {st_wake_osc, st_wake_dcdc, st_wake_charge,
                                            st_slp_blank, st_slp_drain, st_slp_dcdc});
      next_frame_count = '0;
      if (state == st_wake_blank) begin
         next_frame_count = frame_tick ? frame_count + 4'h1 : frame_count;
      end
      next_power = power_for(next_state);
   end

   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         state       <= st_sleep;
         step_start  <= 1'b0;
         frame_count <= '0;
         power_ctrl  <= '0;
         asleep      <= 1'b1;
      end else begin
         state       <= next_state;
         step_start  <= next_step_start;
         frame_count <= next_frame_count;
         power_ctrl  <= next_power;
         asleep      <= (next_state == st_sleep);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Status registers and read response

   always_comb begin
      next_image = `IMAGE_MODE_RESET;
      next_image[`IMAGE_INVERSION_BIT] = display_flags.inversion_active_flag;
      next_image[`IMAGE_ALL_WHITE_BIT] = display_flags.all_white_flag;
      next_image[`IMAGE_ALL_BLACK_BIT] = display_flags.all_black_flag;
      next_signal = signal_mode_bits & `SIGNAL_MODE_MASK;
      next_diag   = self_diagnostic_result;
      if (state == st_wake_blank && next_state == st_awake) begin
         next_diag = `DIAG_RESET;
         next_diag[`DIAG_REG_LOAD_BIT] = diag_checks.reg_load_ok;
         next_diag[`DIAG_FUNCTION_BIT] = diag_checks.function_ok;
         next_diag[`DIAG_ATTACH_BIT]   = diag_checks.attach_ok;
         next_diag[`DIAG_GLASS_BIT]    = diag_checks.glass_ok;
         next_diag[`DIAG_CHECKSUM_BIT] = diag_checks.checksum_mismatch_flag;
      end
      next_rsp_valid   = read_cmd && !partial_mode;
      next_rsp_refused = read_cmd && partial_mode;
      next_rsp_data    = 8'h00;
      if (next_rsp_valid) begin
         unique case (cmd_kind)
            cmd_read_image:  next_rsp_data = image_mode_status;
            cmd_read_signal: next_rsp_data = signal_mode_status;
            cmd_read_diag:   next_rsp_data = self_diagnostic_result;
            default:         next_rsp_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         image_mode_status      <= `IMAGE_MODE_RESET;
         signal_mode_status     <= `SIGNAL_MODE_RESET;
         self_diagnostic_result <= `DIAG_RESET;
         rsp_valid              <= 1'b0;
         rsp_refused            <= 1'b0;
         rsp_data               <= 8'h00;
      end else begin
         image_mode_status      <= next_image;
         signal_mode_status     <= next_signal;
         self_diagnostic_result <= next_diag;
         rsp_valid              <= next_rsp_valid;
         rsp_refused            <= next_rsp_refused;
         rsp_data               <= next_rsp_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst_all);

   property p_read_one_byte;
      read_cmd && !partial_mode |=> rsp_valid && !rsp_refused;
   endproperty
   a_read_one_byte: assert property (p_read_one_byte) else $error("read gave no byte");

   property p_no_spurious_rsp;
      !read_cmd |=> !rsp_valid && !rsp_refused;
   endproperty
   a_no_spurious_rsp: assert property (p_no_spurious_rsp) else $error("unasked response");

   property p_image_bits;
      read_image_mode_cmd && !partial_mode |=>
         rsp_data[`IMAGE_INVERSION_BIT] == $past(display_flags.inversion_active_flag, 2) &&
         rsp_data[`IMAGE_ALL_WHITE_BIT] == $past(display_flags.all_white_flag, 2) &&
         rsp_data[`IMAGE_ALL_BLACK_BIT] == $past(display_flags.all_black_flag, 2) &&
         (rsp_data & ~`IMAGE_MODE_MASK) == 8'h00;
   endproperty
   a_image_bits: assert property (p_image_bits) else $error("image byte wrong");

   property p_signal_mask;
      read_signal_mode_cmd && !partial_mode |=> (rsp_data & ~`SIGNAL_MODE_MASK) == 8'h00;
   endproperty
   a_signal_mask: assert property (p_signal_mask) else $error("signal byte bad bits");

   property p_diag_capture;
      state == st_wake_blank && frame_tick && frame_count == BLANK_LAST |=>
         state == st_awake &&
         self_diagnostic_result[`DIAG_REG_LOAD_BIT] == $past(diag_checks.reg_load_ok) &&
         self_diagnostic_result[`DIAG_FUNCTION_BIT] == $past(diag_checks.function_ok) &&
         self_diagnostic_result[`DIAG_ATTACH_BIT] == $past(diag_checks.attach_ok) &&
         self_diagnostic_result[`DIAG_GLASS_BIT] == $past(diag_checks.glass_ok) &&
         self_diagnostic_result[`DIAG_CHECKSUM_BIT] ==
            $past(diag_checks.checksum_mismatch_flag) &&
         (self_diagnostic_result & `DIAG_ZERO_MASK) == 8'h00;
   endproperty
   a_diag_capture: assert property (p_diag_capture) else $error("diag not captured");

   property p_sleep_ignored;
      state == st_sleep && sleep_enter_cmd |=> state == st_sleep && asleep;
   endproperty
   a_sleep_ignored: assert property (p_sleep_ignored) else $error("sleep-in not ignored");

   property p_wake;
      state == st_sleep && sleep_exit_cmd |=> state == st_wake_osc ##0 power_ctrl.osc_en
         ##1 !power_ctrl.scan_en;
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not start");

   property p_blank_first;
      state == st_awake && sleep_enter_cmd |=> state == st_slp_blank && power_ctrl.blank &&
         power_ctrl.scan_en;
   endproperty
   a_blank_first: assert property (p_blank_first) else $error("sleep-in did not blank");

   property p_sleep_order;
      state == st_slp_drain |=> state inside {st_slp_drain, st_slp_dcdc} &&
         (state != st_slp_dcdc || (!power_ctrl.dcdc_en && power_ctrl.osc_en));
   endproperty
   a_sleep_order: assert property (p_sleep_order) else $error("sleep order wrong");

   property p_asleep_off;
      state == st_sleep |-> !power_ctrl.osc_en && !power_ctrl.dcdc_en && !power_ctrl.scan_en;
   endproperty
   a_asleep_off: assert property (p_asleep_off) else $error("supplies on in sleep");

   property p_sleep_keeps;
      state == st_sleep && !sleep_exit_cmd |=> $stable(self_diagnostic_result);
   endproperty
   a_sleep_keeps: assert property (p_sleep_keeps) else $error("register lost in sleep");

   property p_partial_refused;
      read_cmd && partial_mode |=> rsp_refused && !rsp_valid;
   endproperty
   a_partial_refused: assert property (p_partial_refused) else $error("partial read served");

   property p_reset_sleep;
      disable iff (1'b0) rst_all |=> state == st_sleep && asleep &&
         self_diagnostic_result == `DIAG_RESET && image_mode_status == `IMAGE_MODE_RESET;
   endproperty
   a_reset_sleep: assert property (p_reset_sleep) else $error("reset not to sleep");

   c_full_wake: cover property (state == st_wake_blank ##1 state == st_awake);
   c_full_sleep: cover property (state == st_slp_dcdc ##1 state == st_sleep);
   c_refused: cover property (read_cmd && partial_mode);
   c_diag_read: cover property (state == st_awake && read_self_diag_cmd ##1 rsp_valid);

endmodule : display_status_sleep_cmds

// *** host_model.sv ***
// Host model that sends commands and frame ticks
`timescale 1ns/1ps

module host_model #(
   parameter int WAKE_GAP  = 100000,
   parameter int SLEEP_GAP = 2400000,
   parameter int FRAME_LEN = 8
) (
   input  wire logic   clk_sys,
   output logic        cmd_valid,
   output logic [15:0] cmd_code,
   output logic        frame_tick
);
   int cyc      = 0;
   int wake_cyc = -SLEEP_GAP;
   int frame_cnt = 0;

   initial begin
      cmd_valid  = 1'b0;
      cmd_code   = 16'h0000;
   end

   always @(posedge clk_sys) begin
      cyc        <= cyc + 1;
      frame_cnt  <= (frame_cnt == FRAME_LEN - 1) ? 0 : frame_cnt + 1;
      frame_tick <= (frame_cnt == FRAME_LEN - 1);
   end

   // One code word per command, held until the sampling edge
   task automatic issue(input logic [15:0] code);
      while (cyc - wake_cyc < WAKE_GAP) @(posedge clk_sys);
      if (code == 16'h0010 || code == 16'h1000)
         while (cyc - wake_cyc < SLEEP_GAP) @(posedge clk_sys);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_code  <= code;
      if (code == 16'h0011 || code == 16'h1100)
         wake_cyc = cyc;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      cmd_code  <= ~code;
   endtask : issue
endmodule : host_model

// *** display_status_sleep_cmds_tb.sv ***
// Self-checking bench for the status and sleep command block
`timescale 1ns/1ps

module display_status_sleep_cmds_tb
   import display_status_sleep_pkg::*;
;
   logic           clk_sys = 1'b0;
   logic           reset = 1'b1;
   logic           soft_reset_req = 1'b0;
   logic           partial_mode = 1'b0;
   display_flags_t display_flags = '0;
   logic [7:0]     signal_mode_bits = 8'h00;
   diag_checks_t   diag_checks = '0;
   logic           cmd_valid;
   logic [15:0]    cmd_code;
   logic           frame_tick;
   logic           rsp_valid;
   logic           rsp_refused;
   logic [7:0]     rsp_data;
   power_ctrl_t    power_ctrl;
   logic           asleep;
   int             bad_count = 0;
   int             total_checks = 0;

   always #25 clk_sys = ~clk_sys;

   // Host gaps scaled down to keep the run short
   host_model #(.WAKE_GAP(40), .SLEEP_GAP(120)) host (
      .clk_sys    (clk_sys),
      .cmd_valid  (cmd_valid),
      .cmd_code   (cmd_code),
      .frame_tick (frame_tick)
   );

   display_status_sleep_cmds #(.STEP_CYCLES(2), .BLANK_FRAMES(2)) DUT (
      .clk_sys          (clk_sys),
      .reset            (reset),
      .soft_reset_req   (soft_reset_req),
      .cmd_valid        (cmd_valid),
      .cmd_code         (cmd_code),
      .partial_mode     (partial_mode),
      .display_flags    (display_flags),
      .signal_mode_bits (signal_mode_bits),
      .diag_checks      (diag_checks),
      .frame_tick       (frame_tick),
      .rsp_valid        (rsp_valid),
      .rsp_refused      (rsp_refused),
      .rsp_data         (rsp_data),
      .power_ctrl       (power_ctrl),
      .asleep           (asleep)
   );

   ////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [7:0] exp_image(input display_flags_t f);
      return {2'b00, f, 3'b000};
   endfunction : exp_image

   function automatic logic [7:0] exp_diag(input diag_checks_t d);
      return {d[4:1], 3'b000, d[0]};
   endfunction : exp_diag

   // Read: answer just after the taking edge, gone one cycle later
   task automatic rd(input logic [15:0] code, input logic [7:0] exp);
      host.issue(code);
      #1;
      chk({6'b0, rsp_valid, rsp_refused}, partial_mode ? 8'h01 : 8'h02);
      chk(rsp_data, partial_mode ? 8'h00 : exp);
      @(posedge clk_sys);
      #1;
      chk({6'b0, rsp_valid, rsp_refused}, 8'h00);
      chk(rsp_data, 8'h00);
   endtask : rd

   task automatic wait_pc(input int idx, input logic val, input logic [5:0] exp);
      int n;
      n = 0;
      while (power_ctrl[idx] !== val && n < 50) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk({2'b00, power_ctrl}, {2'b00, exp});
   endtask : wait_pc

   task automatic new_inputs(input int i);
      @(posedge clk_sys);
      display_flags    <= (i < 3) ? 3'(3'b100 >> i) : 3'($urandom);
      signal_mode_bits <= 8'($urandom);
      diag_checks      <= 5'($urandom);
      @(posedge clk_sys);
   endtask : new_inputs

   ////////////////////////////////////////
   initial begin
      void'($urandom(13));
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk({1'b0, asleep, power_ctrl}, 8'h40);
      rd(16'h000F, 8'h00);
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 6; i++) begin
            new_inputs(i);
            rd(i[0] ? 16'h0D00 : 16'h000D, exp_image(display_flags));
            rd(i[0] ? 16'h0E00 : 16'h000E, signal_mode_bits & 8'hC1);
         end
         @(posedge clk_sys);
         partial_mode <= 1'b1;
         rd(16'h000F, 8'h00);
         @(posedge clk_sys);
         partial_mode <= 1'b0;
         host.issue(16'h0A00);
         #1;
         chk({7'b0, rsp_valid}, 8'h00);
         host.issue(r ? 16'h1100 : 16'h0011);
         #1;
         chk({1'b0, asleep, power_ctrl}, 8'h20);
         wait_pc(4, 1'b1, 6'b110000);
         wait_pc(1, 1'b1, 6'b110010);
         wait_pc(3, 1'b1, 6'b111001);
         wait_pc(0, 1'b0, 6'b111000);
         rd(16'h000F, exp_diag(diag_checks));
         host.issue(r ? 16'h1000 : 16'h0010);
         #1;
         chk({2'b00, power_ctrl}, 8'h39);
         wait_pc(2, 1'b1, 6'b110101);
         wait_pc(4, 1'b0, 6'b100001);
         wait_pc(5, 1'b0, 6'b000000);
         chk({7'b0, asleep}, 8'h01);
         host.issue(16'h0010);
         repeat (4) @(posedge clk_sys);
         #1;
         chk({1'b0, asleep, power_ctrl}, 8'h40);
         rd(16'h0F00, exp_diag(diag_checks));
      end
      host.issue(16'h0011);
      wait_pc(4, 1'b1, 6'b110000);
      @(posedge clk_sys);
      soft_reset_req <= 1'b1;
      @(posedge clk_sys);
      soft_reset_req <= 1'b0;
      #1;
      chk({1'b0, asleep, power_ctrl}, 8'h40);
      rd(16'h000F, 8'h00);
      close_out();
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      bad_count++;
      close_out();
   end
endmodule : display_status_sleep_cmds_tb
